/* rtl/gcrp_pkg.sv */
// Constants and carrier types for the rate sensor command/response port
package gcrp_pkg;
	// Timing
	localparam int CLK_NS = 4;
	localparam int GAP_NS = 100; // 0.1 us between frames
	localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	// Synchroniser lanes
	localparam int PIN_SCK = 2;
	localparam int PIN_CSN = 1;
	localparam int PIN_DIN = 0;
	localparam logic [2:0] PIN_RST = 3'h2;
	// Command fields
	localparam int CMD_SENSOR_BIT = 29;
	localparam int CMD_INJ_BIT = 1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	// Register map
	localparam logic [8:0] ADDR_SCR_LO = 9'h000;
	localparam logic [8:0] ADDR_SCR_HI = 9'h002;
	localparam logic [8:0] ADDR_FAULT = 9'h00a;
	localparam int SCR_BYTES = 4;
	// Response words and fields
	localparam logic [31:0] FIRST_WORD = 32'h0000_0001;
	localparam logic [2:0] HDR_READ = 3'h2;
	localparam logic [2:0] HDR_WRITE = 3'h1;
	localparam logic [2:0] HDR_ERR = 3'h0;
	localparam logic [3:0] RSP_FIX = 4'he;
	localparam logic [2:0] MOD_SEL = 3'h0;
	localparam logic [1:0] KIND_INVALID = 2'h0;
	localparam logic [1:0] KIND_VALID = 2'h1;
	localparam logic [1:0] KIND_SELF = 2'h2;
	localparam logic [1:0] KIND_RW = 2'h3;
	localparam int PRI_RAIL = 3;
	localparam int SEC_GROSS = 7;
	localparam logic [7:0] ALARM_RST = 8'h00;

	typedef enum logic [1:0] {
		CK_SENSOR = 2'b00,
		CK_READ = 2'b01,
		CK_WRITE = 2'b10,
		CK_BAD = 2'b11
	} gcrp_kind_t;

	typedef enum logic {
		FS_IDLE = 1'b0,
		FS_FRAME = 1'b1
	} gcrp_state_t;

	typedef struct packed {
		logic lock_loss_fault;
		logic quad_fault;
		logic rom_checksum_fault;
		logic init_fault;
		logic high_rail_fault;
		logic low_rail_fault;
		logic self_test_drift;
		logic resonance_level_fault;
		logic self_test_gross;
	} gcrp_det_t;

	typedef struct packed {
		gcrp_kind_t kind;
		logic [2:0] tag;
		logic [8:0] addr;
		logic [15:0] data;
		logic spi_err;
		logic req_err;
	} gcrp_cmd_t;
endpackage : gcrp_pkg

/* rtl/gcrp_port.sv */
// Command/response serial port of the rate sensor
`timescale 1ns/1ps
// Functional notes
// - Echo request frame tag in sensor data response
// - Module select bits always return zero
// - Address ignored for sensor data requests
// - Read returns addressed and next register
// - Write echoes the stored value
// - Bad bit count or parity flags framing
// - Errors force read/write error format
// - Bad command or register flags illegal
// - Short inter-frame gap may flag no data
// - Response kind codes 00/01/10/11
// - Gross self-test or lock loss gives 00
// - Upper half response has odd parity
// - Whole response word has odd parity
// - Fault flags sticky until read
// - Persisting fault sets flag again immediately
// - Primary alarms appended to sensor responses
// - Address 0x0a reads both alarm registers
// - Gross breakdown flag tracks kind 00
// - Rail fault from high or low rail
// - Self-test fault from self-test or resonance
// - Answer comes in the next frame
// - First exchange sends fixed word 0x00000001
// - Fault inject gives kind 10, all faults
module gcrp_port #(
	parameter int GAP_CYCLES = gcrp_pkg::GAP_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe_n,
	input wire logic [15:0] rate_data,
	input wire gcrp_pkg::gcrp_det_t det
);
	if (GAP_CYCLES < 1 || GAP_CYCLES > 255) begin : g_gap_range
		$error("GAP_CYCLES out of range");
	end

	logic [2:0] s1_ff, s2_ff, s3_ff, pin_ff, prev_ff;
	logic sck_rise, sck_fall, cs_fall, cs_rise;
	gcrp_pkg::gcrp_state_t state_ff;
	logic [31:0] rx_ff, tx_ff, resp_word;
	logic [5:0] cnt_ff;
	logic [7:0] gap_ff;
	logic first_ff, inject_ff, short_gap, err_fmt, fault_clr, wr_ok;
	gcrp_pkg::gcrp_cmd_t pend_ff, nxt_cmd;
	logic [7:0] scr_ff [gcrp_pkg::SCR_BYTES];
	logic [7:0] pri_ff, sec_ff, pri_cond, sec_cond;
	logic [15:0] rd_word;
	logic lock_c, hi_c, lo_c, res_c, gross_c;

	// Three-stage pin sampling; change accepted when stages two and three agree
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_ff <= gcrp_pkg::PIN_RST;
			s2_ff <= gcrp_pkg::PIN_RST;
			s3_ff <= gcrp_pkg::PIN_RST;
			pin_ff <= gcrp_pkg::PIN_RST;
			prev_ff <= gcrp_pkg::PIN_RST;
		end else begin
			s1_ff <= {sclk, cs_n, mosi};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			pin_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (pin_ff & (s2_ff ^ s3_ff));
			prev_ff <= pin_ff;
		end
	end

	assign sck_rise = pin_ff[gcrp_pkg::PIN_SCK] & ~prev_ff[gcrp_pkg::PIN_SCK];
	assign sck_fall = ~pin_ff[gcrp_pkg::PIN_SCK] & prev_ff[gcrp_pkg::PIN_SCK];
	assign cs_fall = ~pin_ff[gcrp_pkg::PIN_CSN] & prev_ff[gcrp_pkg::PIN_CSN];
	assign cs_rise = pin_ff[gcrp_pkg::PIN_CSN] & ~prev_ff[gcrp_pkg::PIN_CSN];

	// Frame state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= gcrp_pkg::FS_IDLE;
		end else begin
			case (state_ff)
				gcrp_pkg::FS_IDLE: if (cs_fall) state_ff <= gcrp_pkg::FS_FRAME;
				gcrp_pkg::FS_FRAME: if (cs_rise) state_ff <= gcrp_pkg::FS_IDLE;
				default: state_ff <= gcrp_pkg::FS_IDLE;
			endcase
		end
	end

	// Receive on rising clock, MSB first, counting bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_ff <= '0;
			cnt_ff <= '0;
		end else if (cs_fall) begin
			cnt_ff <= '0;
		end else if (sck_rise && state_ff == gcrp_pkg::FS_FRAME) begin
			rx_ff <= {rx_ff[30:0], pin_ff[gcrp_pkg::PIN_DIN]};
			if (cnt_ff != 6'h3f) cnt_ff <= cnt_ff + 6'h01;
		end
	end

	// Inter-frame gap timer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_ff <= 8'hff;
		end else if (cs_rise) begin
			gap_ff <= 8'h01;
		end else if (state_ff == gcrp_pkg::FS_IDLE && gap_ff != 8'hff) begin
			gap_ff <= gap_ff + 8'h01;
		end
	end
	assign short_gap = gap_ff < 8'(GAP_CYCLES);

	// Command decode at frame end
	always_comb begin
		nxt_cmd.tag = {rx_ff[28], rx_ff[31], rx_ff[30]};
		nxt_cmd.addr = rx_ff[25:17];
		nxt_cmd.data = rx_ff[16:1];
		nxt_cmd.spi_err = (cnt_ff != gcrp_pkg::FRAME_BITS) || !(^rx_ff);
		if (rx_ff[gcrp_pkg::CMD_SENSOR_BIT]) nxt_cmd.kind = gcrp_pkg::CK_SENSOR;
		else if (rx_ff[31:30] == gcrp_pkg::OP_READ) nxt_cmd.kind = gcrp_pkg::CK_READ;
		else if (rx_ff[31:30] == gcrp_pkg::OP_WRITE) nxt_cmd.kind = gcrp_pkg::CK_WRITE;
		else nxt_cmd.kind = gcrp_pkg::CK_BAD;
		// Sensor requests never look at the address
		case (nxt_cmd.kind)
			gcrp_pkg::CK_SENSOR: nxt_cmd.req_err = 1'b0;
			gcrp_pkg::CK_READ: nxt_cmd.req_err = !(nxt_cmd.addr == gcrp_pkg::ADDR_SCR_LO ||
				nxt_cmd.addr == gcrp_pkg::ADDR_SCR_HI || nxt_cmd.addr == gcrp_pkg::ADDR_FAULT);
			gcrp_pkg::CK_WRITE: nxt_cmd.req_err = !(nxt_cmd.addr == gcrp_pkg::ADDR_SCR_LO ||
				nxt_cmd.addr == gcrp_pkg::ADDR_SCR_HI);
			default: nxt_cmd.req_err = 1'b1;
		endcase
	end

	// Pending command and fault inject latch; answered next frame
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_ff <= '0;
			inject_ff <= 1'b0;
		end else if (cs_rise) begin
			pend_ff <= nxt_cmd;
			if (nxt_cmd.kind == gcrp_pkg::CK_SENSOR && !nxt_cmd.spi_err)
				inject_ff <= rx_ff[gcrp_pkg::CMD_INJ_BIT];
		end
	end

	// Writable scratch bytes, written as a pair
	assign wr_ok = cs_rise && nxt_cmd.kind == gcrp_pkg::CK_WRITE && !nxt_cmd.spi_err &&
		!nxt_cmd.req_err;
	for (genvar i = 0; i < gcrp_pkg::SCR_BYTES; i++) begin : g_scr
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				scr_ff[i] <= '0;
			end else if (wr_ok && nxt_cmd.addr[1] == 1'(i / 2)) begin
				scr_ff[i] <= (i % 2 == 1) ? nxt_cmd.data[7:0] : nxt_cmd.data[15:8];
			end
		end
	end

	// Addressed register and the next one; stored value for write echo
	assign rd_word = (pend_ff.addr == gcrp_pkg::ADDR_FAULT) ? {sec_ff, pri_ff} :
		{scr_ff[{pend_ff.addr[1], 1'b0}], scr_ff[{pend_ff.addr[1], 1'b1}]};

	// Fault conditions, forced while injecting
	assign lock_c = det.lock_loss_fault | inject_ff;
	assign hi_c = det.high_rail_fault | inject_ff;
	assign lo_c = det.low_rail_fault | inject_ff;
	assign res_c = det.resonance_level_fault | inject_ff;
	assign gross_c = det.self_test_gross | lock_c;
	assign pri_cond = {lock_c, det.quad_fault | inject_ff, det.rom_checksum_fault | inject_ff,
		det.init_fault | inject_ff, hi_c | lo_c, det.self_test_drift | res_c, inject_ff,
		1'b0};
	assign sec_cond = {gross_c, res_c, hi_c, lo_c, 4'h0};
	assign fault_clr = cs_fall && !first_ff && pend_ff.kind == gcrp_pkg::CK_READ &&
		!err_fmt && pend_ff.addr == gcrp_pkg::ADDR_FAULT;

	// Sticky alarms; clear on read, a live condition wins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pri_ff <= gcrp_pkg::ALARM_RST;
			sec_ff <= gcrp_pkg::ALARM_RST;
		end else begin
			pri_ff <= (pri_ff & ~{8{fault_clr}}) | pri_cond;
			sec_ff <= (sec_ff & ~{8{fault_clr}}) | sec_cond;
		end
	end

	// Response build from the command latched at the end of the previous frame
	assign err_fmt = pend_ff.spi_err || pend_ff.req_err || short_gap;
	always_comb begin
		if (err_fmt) begin
			resp_word = {gcrp_pkg::HDR_ERR, 1'b0, gcrp_pkg::RSP_FIX, gcrp_pkg::MOD_SEL, 2'b00,
				pend_ff.spi_err, pend_ff.req_err, short_gap, 8'h00, pri_ff[7:1], 1'b0};
		end else if (pend_ff.kind == gcrp_pkg::CK_SENSOR) begin
			resp_word = {pend_ff.tag, 1'b0,
				inject_ff ? gcrp_pkg::KIND_SELF :
				(det.self_test_gross | det.lock_loss_fault) ? gcrp_pkg::KIND_INVALID :
				gcrp_pkg::KIND_VALID, rate_data, 2'b00, pri_ff[7:1], 1'b0};
		end else begin
			resp_word = {pend_ff.kind == gcrp_pkg::CK_READ ? gcrp_pkg::HDR_READ :
				gcrp_pkg::HDR_WRITE, 1'b0, gcrp_pkg::RSP_FIX, gcrp_pkg::MOD_SEL,
				rd_word, 5'h00};
		end
		resp_word[28] = ~^{resp_word[31:29], resp_word[27:16]};
		resp_word[0] = ~^resp_word[31:1];
	end

	// Transmit: load at frame start, shift on falling clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_ff <= '0;
			first_ff <= 1'b1;
		end else if (cs_fall) begin
			tx_ff <= first_ff ? gcrp_pkg::FIRST_WORD : resp_word;
			first_ff <= 1'b0;
		end else if (sck_fall && state_ff == gcrp_pkg::FS_FRAME) begin
			tx_ff <= {tx_ff[30:0], 1'b0};
		end
	end
	assign miso = tx_ff[31];
	assign miso_oe_n = state_ff != gcrp_pkg::FS_FRAME;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_first;
		cs_fall && first_ff |=> tx_ff == gcrp_pkg::FIRST_WORD;
	endproperty
	a_first: assert property (p_first) else $error("first word wrong");
	property p_tag;
		cs_fall && !first_ff && !err_fmt && pend_ff.kind == gcrp_pkg::CK_SENSOR
			|=> tx_ff[31:29] == $past(pend_ff.tag);
	endproperty
	a_tag: assert property (p_tag) else $error("tag not echoed");
	property p_sm;
		cs_fall && !first_ff && (err_fmt || pend_ff.kind != gcrp_pkg::CK_SENSOR)
			|=> tx_ff[23:21] == 3'h0 && tx_ff[27:24] == gcrp_pkg::RSP_FIX;
	endproperty
	a_sm: assert property (p_sm) else $error("module select nonzero");
	property p_par;
		cs_fall && !first_ff |=> ^tx_ff[31:16] && ^tx_ff;
	endproperty
	a_par: assert property (p_par) else $error("response parity");
	property p_frame;
		cs_rise && cnt_ff != gcrp_pkg::FRAME_BITS |=> pend_ff.spi_err;
	endproperty
	a_frame: assert property (p_frame) else $error("framing missed");
	property p_errfmt;
		cs_fall && !first_ff && pend_ff.spi_err |=> tx_ff[31:29] == 3'h0 && tx_ff[18];
	endproperty
	a_errfmt: assert property (p_errfmt) else $error("error format");
	property p_illegal;
		cs_rise && nxt_cmd.kind == gcrp_pkg::CK_BAD |=> pend_ff.req_err;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal missed");
	property p_rail;
		det.high_rail_fault || det.low_rail_fault |=> pri_ff[gcrp_pkg::PRI_RAIL] [*2];
	endproperty
	a_rail: assert property (p_rail) else $error("rail flag");
	property p_sticky;
		pri_ff[gcrp_pkg::PRI_RAIL] && !fault_clr |=> pri_ff[gcrp_pkg::PRI_RAIL];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
	property p_inject;
		cs_fall && !first_ff && !err_fmt && inject_ff && pend_ff.kind == gcrp_pkg::CK_SENSOR
			|=> tx_ff[27:26] == gcrp_pkg::KIND_SELF;
	endproperty
	a_inject: assert property (p_inject) else $error("inject kind");
	property p_gross;
		det.self_test_gross |=> sec_ff[gcrp_pkg::SEC_GROSS];
	endproperty
	a_gross: assert property (p_gross) else $error("gross flag");
	property p_shift;
		sck_fall && state_ff == gcrp_pkg::FS_FRAME && !cs_fall |=> miso == $past(tx_ff[30]);
	endproperty
	a_shift: assert property (p_shift) else $error("shift order");

	property p_gap;
		cs_fall && !first_ff && short_gap |=> tx_ff[16];
	endproperty
	a_gap: assert property (p_gap) else $error("no data flag missing");
	property p_kind_bad;
		cs_fall && !first_ff && !err_fmt && !inject_ff && pend_ff.kind == gcrp_pkg::CK_SENSOR &&
			det.lock_loss_fault |=> tx_ff[27:26] == gcrp_pkg::KIND_INVALID;
	endproperty
	a_kind_bad: assert property (p_kind_bad) else $error("invalid kind missing");
	property p_rw_kind;
		cs_fall && !first_ff && !err_fmt && pend_ff.kind != gcrp_pkg::CK_SENSOR
			|=> tx_ff[27:26] == gcrp_pkg::KIND_RW;
	endproperty
	a_rw_kind: assert property (p_rw_kind) else $error("read/write kind");
	property p_clear;
		fault_clr && pri_cond == 8'h00 |=> pri_ff == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");

	c_first: cover property (cs_fall && first_ff);
	c_fault_rd: cover property (fault_clr);
	c_inject: cover property (cs_fall && inject_ff && !err_fmt);
	c_no_data: cover property (cs_fall && !first_ff && short_gap);
	c_bad_frame: cover property (cs_rise && nxt_cmd.spi_err);
endmodule : gcrp_port

/* verification/gcrp_master.sv */
// Serial bus master model driving the sensor port
`timescale 1ns/1ps
module gcrp_master (
	input wire logic clk,
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso,
	input wire logic miso_oe_n
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// One frame of nb bits after gap idle cycles
	task automatic xfer(input logic [31:0] c, input int nb, input int gap, output logic [31:0] r);
		r = 32'h0;
		repeat (gap) @(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			mosi <= c[31 - i];
			repeat (8) @(posedge clk);
			sclk <= 1'b1;
			r = {r[30:0], miso_oe_n ? 1'b1 : miso};
			repeat (8) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge clk);
		cs_n <= 1'b1;
		mosi <= ~mosi;
	endtask : xfer
endmodule : gcrp_master

/* verification/gcrp_port_tb.sv */
// Self-checking bench for the sensor command/response port
`timescale 1ns/1ps
module gcrp_port_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] rate_data = 16'h0000;
	gcrp_pkg::gcrp_det_t det = '0;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe_n;
	int bad_count = 0;
	int checked = 0;
	logic [31:0] pend;
	logic [31:0] rsp;
	int pal;
	logic [7:0] al;
	logic [1:0] kd;
	always #2 clk = ~clk;
	gcrp_port u_dut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe_n(miso_oe_n), .rate_data(rate_data), .det(det));
	gcrp_master u_m (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.miso_oe_n(miso_oe_n));
	function automatic logic [31:0] fix(input logic [31:0] w);
		w[28] = 1'b0;
		w[0] = 1'b0;
		w[28] = ~^w[31:16];
		w[0] = ~^w;
		return w;
	endfunction : fix
	function automatic logic [31:0] odd(input logic [31:0] c);
		c[0] = ~^c[31:1];
		return c;
	endfunction : odd
	function automatic logic [31:0] scmd(input logic [2:0] t, input logic k, input logic [25:0] j);
		return odd({t[1:0], 1'b1, t[2], j, k, 1'b0});
	endfunction : scmd
	function automatic logic [31:0] rw(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d);
		return odd({op, 4'h0, a, d, 1'b0});
	endfunction : rw
	function automatic logic [31:0] fw(input logic [2:0] h, input logic [15:0] d);
		return {h, 1'b0, 4'he, 3'h0, d, 5'h00};
	endfunction : fw
	function automatic logic [31:0] fe(input logic s, input logic r, input logic u);
		return {8'h0e, 5'h00, s, r, u, 16'h0000};
	endfunction : fe
	function automatic logic [31:0] fs(input logic [2:0] t);
		return {t, 3'h0, rate_data, 10'h000};
	endfunction : fs
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	// Checks the answer to the previous frame, then queues the next one
	task automatic go(input logic [31:0] c, input logic [31:0] nx, input int p, input int nb = 32,
		input int gap = 30);
		logic [31:0] e;
		u_m.xfer(c, nb, gap, rsp);
		e = pend;
		if (p >= 0 && pal == 1 || pal == 2) e[7:1] = al[7:1];
		if (pal == 2) e[27:26] = kd;
		if (pal != 3) e = fix(e);
		cmp("response", e >> (32 - nb), rsp);
		pend = nx;
		pal = p;
	endtask : go
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		summarize();
	end
	initial begin
		logic [2:0] t;
		logic [15:0] d;
		void'($urandom(32'he7eb));
		pend = gcrp_pkg::FIRST_WORD;
		pal = 3;
		al = 8'h00;
		kd = gcrp_pkg::KIND_VALID;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		cmp("idle pins", 32'h2, {30'h0, miso_oe_n, miso});
		for (int i = 0; i < 6; i++) begin
			t = 3'($urandom);
			d = 16'($urandom);
			rate_data <= 16'($urandom);
			@(posedge clk);
			go(scmd(t, 1'b0, 26'($urandom)), fs(t), 2);
			go(rw(gcrp_pkg::OP_WRITE, {7'h0, i[0], 1'b0}, d), fw(gcrp_pkg::HDR_WRITE, d), 0);
			go(rw(gcrp_pkg::OP_READ, {7'h0, i[0], 1'b0}, 16'h0), fw(gcrp_pkg::HDR_READ, d), 0);
		end
		go(rw(gcrp_pkg::OP_READ, 9'h005, 16'h0), fe(0, 1, 0), 1);
		go(rw(gcrp_pkg::OP_WRITE, gcrp_pkg::ADDR_FAULT, 16'h1234), fe(0, 1, 0), 1);
		go(rw(2'h3, 9'h000, 16'h0000), fe(0, 1, 0), 1);
		go(scmd(3'h5, 1'b0, 26'h0) ^ 32'h1, fe(1, 0, 0), 1);
		go(scmd(3'h2, 1'b0, 26'h0), fs(3'h2), 2);
		go(scmd(3'h3, 1'b0, 26'h0), fe(1, 0, 0), 1, 31);
		det.high_rail_fault <= 1'b1;
		det.self_test_gross <= 1'b1;
		repeat (3) @(posedge clk);
		det.high_rail_fault <= 1'b0;
		det.self_test_gross <= 1'b0;
		al = 8'h08;
		go(scmd(3'h4, 1'b0, 26'h0), fs(3'h4), 2);
		go(rw(gcrp_pkg::OP_READ, gcrp_pkg::ADDR_FAULT, 16'h0), fw(3'h2, 16'ha008), 0);
		go(rw(gcrp_pkg::OP_READ, gcrp_pkg::ADDR_FAULT, 16'h0), fw(3'h2, 16'h0000), 0);
		al = 8'h00;
		go(scmd(3'h6, 1'b0, 26'h0), fs(3'h6), 2);
		det.lock_loss_fault <= 1'b1;
		al = 8'h80;
		kd = gcrp_pkg::KIND_INVALID;
		@(posedge clk);
		go(rw(gcrp_pkg::OP_READ, gcrp_pkg::ADDR_FAULT, 16'h0), fw(3'h2, 16'h8080), 0);
		go(rw(gcrp_pkg::OP_READ, gcrp_pkg::ADDR_FAULT, 16'h0), fw(3'h2, 16'h8080), 0);
		go(scmd(3'h1, 1'b1, 26'h0), fs(3'h1), 2);
		det.lock_loss_fault <= 1'b0;
		al = 8'hfe;
		kd = gcrp_pkg::KIND_SELF;
		go(scmd(3'h7, 1'b1, 26'h0), fe(0, 0, 1), 1);
		go(scmd(3'h0, 1'b0, 26'h0), 32'h0, 3, 32, 4);
		summarize();
	end
endmodule : gcrp_port_tb
